// >>> cmcr_pkg.sv
// constants and types for the custom microstep current reference
// assumes a single 125 MHz clock and an 8-bit register write port
package cmcr_pkg;
    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 125000000;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int STEP_MAX_HZ = 300000;
    localparam int STEP_MIN_HZ = 10;
    // least step interval, rounded up
    localparam int MIN_STEP_CYC = (CLK_HZ + STEP_MAX_HZ - 1) / STEP_MAX_HZ;
    // longest step interval, rounded down
    localparam int SLOW_STEP_CYC = CLK_HZ / STEP_MIN_HZ;
    localparam int OFF_TIME_NS = 7000;
    // ----------------------------------------------------------------
    // register indexes and reset values
    // ----------------------------------------------------------------
    localparam int PTS = 8;
    localparam logic [3:0] IDX_PT_LAST = 4'h7;
    localparam logic [3:0] IDX_FS = 4'h8;
    localparam logic [3:0] IDX_HOLD = 4'h9;
    localparam logic [3:0] IDX_POS_A = 4'hA;
    localparam logic [7:0] RST_PT = 8'h00;
    localparam logic [7:0] RST_FS = 8'hFF;
    localparam logic [7:0] RST_HOLD = 8'h40;
    // ----------------------------------------------------------------
    // position layout
    // ----------------------------------------------------------------
    localparam logic [9:0] HOME_POS = 10'h080;
    localparam logic [3:0] MAX_SHIFT = 4'h8;
    localparam logic [7:0] CODE_ALL = 8'hFF;
    localparam int SEG_LSB = 5;
    typedef enum logic {CHOP_DRIVE = 1'b0, CHOP_DECAY = 1'b1} chop_t;
    // built-in sine points at 1/8 spacing, 11.25 deg to 90 deg
    function automatic logic [7:0] sine_point(input logic [2:0] k);
        logic [7:0] v;
        v = 8'h00;
        case (k)
            3'h0: v = 8'h32;
            3'h1: v = 8'h62;
            3'h2: v = 8'h8E;
            3'h3: v = 8'hB4;
            3'h4: v = 8'hD4;
            3'h5: v = 8'hEC;
            3'h6: v = 8'hFA;
            3'h7: v = 8'hFF;
        endcase
        return v;
    endfunction : sine_point
endpackage : cmcr_pkg

// >>> custom_microstep_current_ref.sv
// coil current reference: indexer, profile interpolation, scaling, chop
// assumes step and trip inputs are asynchronous pins, register port is
// on CLK
// Functional notes
// - with the custom enable set, currents come from the programmed points.
// - eight point registers hold first-quadrant coil A levels at 1/8 steps.
// - points sit at 11.25 deg spacing up to 90 deg in register order.
// - the current at zero degrees is zero, giving nine points.
// - nine points are joined by straight lines into 256 quadrant values.
// - the custom waveform is always indexed at 1/256 resolution.
// - the quadrant is mirrored for all quadrants of both coils.
// - reaching the trip threshold starts decay for the off time, then drive.
// - pin mode uses full scale only; serial mode applies the two codes.
// - the torque code scales in 1/256 steps, reset all ones for 100%.
// - the hold code sets standstill current, reset giving 25.39%.
`timescale 1ns/1ps
module custom_microstep_current_ref #(
    parameter int SLOW_STEP_CYC = cmcr_pkg::SLOW_STEP_CYC,
    parameter int OFF_TIME_NS = cmcr_pkg::OFF_TIME_NS
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic STEP,
    input wire logic DIR,
    input wire logic [3:0] STEP_SHIFT,
    input wire logic IDX_RESET,
    input wire logic SERIAL_MODE,
    input wire logic CUSTOM_EN,
    input wire logic AUTO_EN,
    input wire logic HOLD,
    input wire logic TRIP_A,
    input wire logic TRIP_B,
    input wire logic WR_EN,
    input wire logic [3:0] WR_INDEX,
    input wire logic [7:0] WR_DATA,
    input wire logic [3:0] RD_INDEX,
    output logic [7:0] RD_DATA,
    output logic [7:0] CUR_A,
    output logic [7:0] CUR_B,
    output logic SIGN_A,
    output logic SIGN_B,
    output logic DRIVE_A,
    output logic DRIVE_B,
    output logic RATE_FAULT
);
    localparam int OFF_CYC =
        (OFF_TIME_NS * 1000 + cmcr_pkg::CLK_PERIOD_PS - 1) /
        cmcr_pkg::CLK_PERIOD_PS;
    localparam int GW = $clog2(SLOW_STEP_CYC + 1);
    localparam logic [GW-1:0] MIN_GAP = GW'(cmcr_pkg::MIN_STEP_CYC);
    localparam logic [GW-1:0] MAX_GAP = GW'(SLOW_STEP_CYC);
    localparam logic [11:0] OFF_LOAD = 12'(OFF_CYC - 1);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] pt_r [0:cmcr_pkg::PTS-1];
    logic [7:0] fs_r;
    logic [7:0] hold_r;
    logic [9:0] pos_r;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < cmcr_pkg::PTS; i++) begin
                pt_r[i] <= cmcr_pkg::RST_PT;
            end
            fs_r <= cmcr_pkg::RST_FS;
            hold_r <= cmcr_pkg::RST_HOLD;
        end else if (WR_EN) begin
            if (WR_INDEX <= cmcr_pkg::IDX_PT_LAST) begin
                pt_r[WR_INDEX[2:0]] <= WR_DATA;
            end else if (WR_INDEX == cmcr_pkg::IDX_FS) begin
                fs_r <= WR_DATA;
            end else if (WR_INDEX == cmcr_pkg::IDX_HOLD) begin
                hold_r <= WR_DATA;
            end
        end
    end

    // unmapped indexes read as zero
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RD_DATA <= 8'h00;
        end else if (RD_INDEX <= cmcr_pkg::IDX_PT_LAST) begin
            RD_DATA <= pt_r[RD_INDEX[2:0]];
        end else if (RD_INDEX == cmcr_pkg::IDX_FS) begin
            RD_DATA <= fs_r;
        end else if (RD_INDEX == cmcr_pkg::IDX_HOLD) begin
            RD_DATA <= hold_r;
        end else if (RD_INDEX == cmcr_pkg::IDX_POS_A) begin
            RD_DATA <= pos_r[7:0];
        end else begin
            RD_DATA <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // step input and indexer
    // ----------------------------------------------------------------
    logic [1:0] step_sync_r;
    logic [1:0] dir_sync_r;
    logic step_prev_r;
    logic step_edge;
    logic [3:0] shift_eff;
    logic [9:0] inc;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            step_sync_r <= 2'h0;
            dir_sync_r <= 2'h0;
            step_prev_r <= 1'h0;
        end else begin
            step_sync_r <= {step_sync_r[0], STEP};
            dir_sync_r <= {dir_sync_r[0], DIR};
            step_prev_r <= step_sync_r[1];
        end
    end

    assign step_edge = step_sync_r[1] & ~step_prev_r;
    assign shift_eff = (STEP_SHIFT > cmcr_pkg::MAX_SHIFT) ?
        cmcr_pkg::MAX_SHIFT : STEP_SHIFT;
    assign inc = 10'h001 << shift_eff;

    // position always counts in 1/256 units so coarse modes still land on it
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pos_r <= cmcr_pkg::HOME_POS;
        end else if (IDX_RESET) begin
            pos_r <= cmcr_pkg::HOME_POS;
        end else if (step_edge) begin
            pos_r <= dir_sync_r[1] ? pos_r + inc : pos_r - inc;
        end
    end

    // ----------------------------------------------------------------
    // step rate monitor
    // ----------------------------------------------------------------
    logic [GW-1:0] gap_r;
    logic seen_r;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            gap_r <= '0;
            seen_r <= 1'h0;
            RATE_FAULT <= 1'h0;
        end else if (step_edge) begin
            gap_r <= '0;
            seen_r <= 1'h1;
            RATE_FAULT <= seen_r & (CUSTOM_EN | AUTO_EN) &
                (gap_r < MIN_GAP);
        end else if (gap_r != MAX_GAP) begin
            gap_r <= gap_r + 1'b1;
        end else if (AUTO_EN & seen_r) begin
            RATE_FAULT <= 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // profile points and interpolation
    // ----------------------------------------------------------------
    logic [7:0] ytab [0:cmcr_pkg::PTS];
    assign ytab[0] = 8'h00;
    for (genvar k = 0; k < cmcr_pkg::PTS; k++) begin : g_pts
        assign ytab[k+1] = CUSTOM_EN ? pt_r[k] :
            cmcr_pkg::sine_point(3'(k));
    end

    // mirroring: odd quadrants read the table backwards, coil b is the
    // complement of coil a
    logic [1:0] quad;
    logic [7:0] qpos [0:1];
    logic [1:0] sign;
    assign quad = pos_r[9:8];
    assign qpos[0] = quad[0] ? ~pos_r[7:0] : pos_r[7:0];
    assign qpos[1] = ~qpos[0];
    assign sign[0] = ~quad[1];
    assign sign[1] = ~(quad[1] ^ quad[0]);

    // serial mode picks a code, pin mode runs at the bare reference
    logic [7:0] code;
    assign code = !SERIAL_MODE ? cmcr_pkg::CODE_ALL :
        (HOLD ? hold_r : fs_r);

    logic [1:0] trip_in;
    logic [1:0] drive;
    logic [7:0] cur [0:1];
    logic [7:0] mag [0:1];
    assign trip_in = {TRIP_B, TRIP_A};

    for (genvar c = 0; c < 2; c++) begin : g_coil
        logic [2:0] seg;
        logic [4:0] frac;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [12:0] span;
        logic [15:0] prod;
        logic [1:0] trip_sync_r;
        logic [11:0] off_r;
        cmcr_pkg::chop_t chop_r;

        assign seg = qpos[c][7:cmcr_pkg::SEG_LSB];
        assign frac = qpos[c][cmcr_pkg::SEG_LSB-1:0];
        assign lo = ytab[seg];
        assign hi = ytab[4'(seg) + 4'h1];
        // result stays between lo and hi, so eight bits never overflow
        assign span = (hi >= lo) ? 13'(hi - lo) * 13'(frac) :
            13'(lo - hi) * 13'(frac);
        assign mag[c] = (hi >= lo) ?
            lo + span[12:cmcr_pkg::SEG_LSB] :
            lo - span[12:cmcr_pkg::SEG_LSB];
        assign prod = 16'(mag[c]) * (16'(code) + 16'h0001);

        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                cur[c] <= 8'h00;
            end else begin
                cur[c] <= prod[15:8];
            end
        end

        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                trip_sync_r <= 2'h0;
            end else begin
                trip_sync_r <= {trip_sync_r[0], trip_in[c]};
            end
        end

        always_ff @(posedge CLK or negedge RSTN) begin
            if (!RSTN) begin
                chop_r <= cmcr_pkg::CHOP_DRIVE;
                off_r <= 12'h000;
            end else begin
                unique case (chop_r)
                    cmcr_pkg::CHOP_DRIVE: begin
                        if (trip_sync_r[1]) begin
                            chop_r <= cmcr_pkg::CHOP_DECAY;
                            off_r <= OFF_LOAD;
                        end
                    end
                    cmcr_pkg::CHOP_DECAY: begin
                        if (off_r == 12'h000) begin
                            chop_r <= cmcr_pkg::CHOP_DRIVE;
                        end else begin
                            off_r <= off_r - 12'h001;
                        end
                    end
                endcase
            end
        end

        assign drive[c] = (chop_r == cmcr_pkg::CHOP_DRIVE);

        a_trip_decay: assert property (
            drive[c] && trip_sync_r[1] |=> !drive[c])
            else $error("trip did not start decay");
        a_decay_hold: assert property (
            $fell(drive[c]) |-> !drive[c] [*8])
            else $error("decay ended early");
        a_decay_end: assert property (
            $fell(drive[c]) |-> ##[1:1000] drive[c])
            else $error("decay never ended");
    end

    assign CUR_A = cur[0];
    assign CUR_B = cur[1];
    assign DRIVE_A = drive[0];
    assign DRIVE_B = drive[1];

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            SIGN_A <= 1'h1;
            SIGN_B <= 1'h1;
        end else begin
            SIGN_A <= sign[0];
            SIGN_B <= sign[1];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_zero_point: assert property (
        qpos[0] == 8'h00 |-> mag[0] == 8'h00)
        else $error("zero angle not zero");
    a_point_place: assert property (
        qpos[0][4:0] == 5'h00 && CUSTOM_EN && qpos[0] != 8'h00 |->
        mag[0] == pt_r[qpos[0][7:5] - 3'h1])
        else $error("point misplaced");
    a_mirror_pair: assert property (
        qpos[1] == ~qpos[0] && sign[0] == ~pos_r[9])
        else $error("mirror broken");
    // reset-time edge loads zero, so skip the first edge after release
    a_scale_out: assert property (
        $past(RSTN) |-> CUR_A == 8'(({8'h00, $past(mag[0])} *
        ({8'h00, $past(code)} + 16'h0001)) >> 8))
        else $error("scaled current wrong");
    a_pin_full: assert property (
        !SERIAL_MODE |-> code == cmcr_pkg::CODE_ALL)
        else $error("pin mode scaled");
    a_step_fwd: assert property (
        step_edge && dir_sync_r[1] && !IDX_RESET |=>
        pos_r == $past(pos_r) + $past(inc))
        else $error("step advance wrong");
    a_home_reset: assert property (
        IDX_RESET |=> pos_r == cmcr_pkg::HOME_POS)
        else $error("index reset missed home");
    a_fast_fault: assert property (
        step_edge && seen_r && CUSTOM_EN && gap_r < MIN_GAP |=>
        RATE_FAULT)
        else $error("fast step not flagged");
    a_sine_sel: assert property (
        !CUSTOM_EN |-> ytab[8] == 8'hFF)
        else $error("builtin profile not used");

    c_custom_step: cover property (CUSTOM_EN && step_edge);
    c_hold_mode: cover property (SERIAL_MODE && HOLD && CUR_A != 8'h00);
    c_chop_cycle: cover property ($rose(DRIVE_A));
    c_quad_wrap: cover property (step_edge && pos_r == 10'h3FF);
endmodule : custom_microstep_current_ref

// >>> custom_microstep_current_ref_tb.sv
// self-checking bench for the custom microstep current reference
// assumes the controller model drives step and register lines
`timescale 1ns/1ps
module custom_microstep_current_ref_tb;
    // ----------------------------------------------------------------
    // setup
    // ----------------------------------------------------------------
    localparam int SLOW = 2000;
    localparam int OFF_NS = 200;
    localparam int GAP = 430;
    logic clk = 1'b0;
    logic rstn, step, dir, idx_reset, serial, custom, auto_en, hold;
    logic trip_a, trip_b, wr_en, sign_a, sign_b, drive_a, drive_b, fault;
    logic [3:0] shift, wr_index, rd_index;
    logic [7:0] wr_data, rd_data, cur_a, cur_b, fs, hd;
    logic [7:0] pts [8];
    logic [9:0] pos;
    logic [31:0] seed;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    always #4 clk = ~clk;
    step_ctrl_model ctl_u (.CLK(clk), .STEP(step), .DIR(dir),
        .WR_EN(wr_en), .WR_INDEX(wr_index), .WR_DATA(wr_data));
    custom_microstep_current_ref #(.SLOW_STEP_CYC(SLOW),
        .OFF_TIME_NS(OFF_NS)) dut_u (.CLK(clk), .RSTN(rstn), .STEP(step),
        .DIR(dir), .STEP_SHIFT(shift), .IDX_RESET(idx_reset),
        .SERIAL_MODE(serial), .CUSTOM_EN(custom), .AUTO_EN(auto_en),
        .HOLD(hold), .TRIP_A(trip_a), .TRIP_B(trip_b), .WR_EN(wr_en),
        .WR_INDEX(wr_index), .WR_DATA(wr_data), .RD_INDEX(rd_index),
        .RD_DATA(rd_data), .CUR_A(cur_a), .CUR_B(cur_b), .SIGN_A(sign_a),
        .SIGN_B(sign_b), .DRIVE_A(drive_a), .DRIVE_B(drive_b),
        .RATE_FAULT(fault));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [7:0] ypt(input int k);
        logic [7:0] sn [8] = '{8'h32, 8'h62, 8'h8E, 8'hB4, 8'hD4, 8'hEC,
            8'hFA, 8'hFF};
        if (k == 0) return 8'h00;
        return custom ? pts[k - 1] : sn[k - 1];
    endfunction : ypt
    // straight line between neighbours, 32 sub-steps per segment
    function automatic logic [7:0] mag(input logic [7:0] q);
        logic [7:0] a;
        logic [7:0] b;
        logic [12:0] t;
        a = ypt(int'(q[7:5]));
        b = ypt(int'(q[7:5]) + 1);
        t = ((b >= a) ? b - a : a - b) * q[4:0];
        return (b >= a) ? a + t[12:5] : a - t[12:5];
    endfunction : mag
    function automatic logic [7:0] scaled(input logic [7:0] m);
        logic [7:0] c;
        logic [16:0] p;
        c = !serial ? 8'hFF : (hold ? hd : fs);
        p = m * (c + 9'h001);
        return p[15:8];
    endfunction : scaled
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_cur;
        logic [7:0] qa;
        #1;
        qa = pos[8] ? 8'hFF - pos[7:0] : pos[7:0];
        chk("cur_a", scaled(mag(qa)), cur_a);
        chk("cur_b", scaled(mag(8'hFF - qa)), cur_b);
        chk("sign_a", {7'h00, !pos[9]}, {7'h00, sign_a});
        chk("sign_b", {7'h00, pos[9] == pos[8]}, {7'h00, sign_b});
        @(posedge clk);
    endtask : chk_cur
    task automatic rd(input logic [3:0] i, input logic [7:0] e);
        @(posedge clk);
        rd_index <= i;
        repeat (2) @(posedge clk);
        #1;
        chk("rd_data", e, rd_data);
        @(posedge clk);
    endtask : rd
    task automatic mv(input logic dv, input int gap);
        ctl_u.step(dv, gap);
        pos = dv ? pos + (10'h001 << (shift > 8 ? 8 : shift))
            : pos - (10'h001 << (shift > 8 ? 8 : shift));
        chk_cur();
    endtask : mv
    task automatic stop_test;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'h4A7DBBA1;
        {rstn, idx_reset, serial, custom, auto_en, hold} = 6'h00;
        {trip_a, trip_b, shift, rd_index} = 10'h000;
        foreach (pts[i]) pts[i] = 8'h00;
        fs = 8'hFF;
        hd = 8'h40;
        pos = 10'h080;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk_cur();
        rd(4'h8, 8'hFF);
        rd(4'h9, 8'h40);
        rd(4'h0, 8'h00);
        rd(4'hA, 8'h80);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            pts[i] = (i == 3) ? 8'hFF : (i == 4) ? 8'h00 : seed[7:0];
            ctl_u.wr(i[3:0], pts[i]);
        end
        ctl_u.wr(4'hC, 8'h5A);
        rd(4'h7, pts[7]);
        rd(4'h8, 8'hFF);
        custom <= 1'b1;
        seed = xs(seed);
        fs = seed[7:0] | 8'h80;
        hd = fs >> 1;
        ctl_u.wr(4'h8, fs);
        ctl_u.wr(4'h9, hd);
        repeat (4) @(posedge clk);
        chk_cur();
        serial <= 1'b1;
        repeat (4) @(posedge clk);
        chk_cur();
        hold <= 1'b1;
        repeat (4) @(posedge clk);
        chk_cur();
        hold <= 1'b0;
        auto_en <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            shift <= (k < 10) ? 4'h0 : seed[3:0];
            mv(seed[4], GAP);
            chk("fault", 8'h00, {7'h00, fault});
        end
        rd(4'hA, pos[7:0]);
        idx_reset <= 1'b1;
        @(posedge clk);
        idx_reset <= 1'b0;
        pos = 10'h080;
        repeat (3) @(posedge clk);
        chk_cur();
        repeat (SLOW + 50) @(posedge clk);
        chk("fault", 8'h01, {7'h00, fault});
        auto_en <= 1'b0;
        // a call's gap sets the interval before the next step edge
        mv(1'b1, 100);
        chk("fault", 8'h00, {7'h00, fault});
        mv(1'b1, GAP);
        chk("fault", 8'h01, {7'h00, fault});
        mv(1'b0, GAP);
        chk("fault", 8'h00, {7'h00, fault});
        @(posedge clk);
        trip_a <= 1'b1;
        n = 0;
        for (int c = 0; c < 80; c++) begin
            @(posedge clk);
            if (c == 2) trip_a <= 1'b0;
            #1;
            n += (drive_a === 1'b0) + 2 * (drive_b !== 1'b1);
        end
        chk("decay", 8'(OFF_NS / 8), 8'(n));
        stop_test();
    end
endmodule : custom_microstep_current_ref_tb

// >>> step_ctrl_model.sv
// partner model: system controller issuing step pulses and register writes
// assumes CLK is the design clock; the bench calls the tasks by path
`timescale 1ns/1ps
module step_ctrl_model (
    input wire logic CLK,
    output logic STEP,
    output logic DIR,
    output logic WR_EN,
    output logic [3:0] WR_INDEX,
    output logic [7:0] WR_DATA
);
    // ----------------------------------------------------------------
    // drivers
    // ----------------------------------------------------------------
    initial begin
        STEP = 1'b0;
        DIR = 1'b1;
        WR_EN = 1'b0;
        WR_INDEX = 4'h0;
        WR_DATA = 8'h00;
    end
    // one-cycle strobe; lines inverted once released
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        @(posedge CLK);
        WR_EN <= 1'b1;
        WR_INDEX <= idx;
        WR_DATA <= d;
        @(posedge CLK);
        WR_EN <= 1'b0;
        WR_INDEX <= ~idx;
        WR_DATA <= ~d;
    endtask : wr
    // gap is rising edge to rising edge; dir settles before the edge
    task automatic step(input logic dv, input int gap);
        @(posedge CLK);
        DIR <= dv;
        repeat (3) @(posedge CLK);
        STEP <= 1'b1;
        repeat (8) @(posedge CLK);
        STEP <= 1'b0;
        repeat (gap - 12) @(posedge CLK);
    endtask : step
endmodule : step_ctrl_model
